/* File: rtl/pmw_pkg.sv */
// Constants, register map and types for the power mode and wake controller
package pmw_pkg;
  localparam int          NUM_PINS    = 19;
  localparam int          ADDR_W      = 4;
  // Register word indices; byte address is four times the index
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATE   = 4'h1;
  localparam logic [3:0]  REG_WAKE_EN = 4'h2;
  localparam logic [3:0]  REG_TRIG_LO = 4'h3;
  localparam logic [3:0]  REG_TRIG_HI = 4'h4;
  localparam logic [3:0]  REG_DIR     = 4'h5;
  localparam logic [3:0]  REG_PULL_UP = 4'h6;
  localparam logic [3:0]  REG_PULL_DN = 4'h7;
  localparam logic [3:0]  REG_IN_DIS  = 4'h8;
  localparam logic [3:0]  REG_OUT     = 4'h9;
  localparam logic [3:0]  REG_PIN_IN  = 4'hA;
  localparam logic [3:0]  REG_IRQ_ST  = 4'hB;
  localparam logic [3:0]  REG_IRQ_MSK = 4'hC;
  localparam logic [3:0]  REG_IRQ_SRC = 4'hD;
  // Control register fields
  localparam int          CTRL_SLEEP  = 0;
  localparam int          CTRL_OFF    = 1;
  // Interrupt status fields
  localparam int          IRQ_WOKE    = 0;
  localparam int          IRQ_RESTART = 1;
  localparam int          IRQ_ERR     = 2;
  localparam logic [31:0] UNMAPPED_RD = 32'hDEAD_BEEF;
  // Trigger encoding per pin: {hi,lo}
  localparam logic [1:0]  TRIG_LOW    = 2'h0;
  localparam logic [1:0]  TRIG_HIGH   = 2'h1;
  localparam logic [1:0]  TRIG_CHANGE = 2'h2;
  // External reset minimum low time
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          RST_MIN_MS  = 100;
  localparam int          RST_CYCLES  = (CLK_HZ / 1000) * RST_MIN_MS;
  localparam int          SYSRST_LEN  = 16;
  typedef enum logic [1:0] {
    PMW_RUN   = 2'b00,
    PMW_SLEEP = 2'b01,
    PMW_OFF   = 2'b11,
    PMW_RESET = 2'b10
  } pmw_state_t;
endpackage

/* File: rtl/pmw_wake_detect.sv */
// Per-pin wake trigger detection with synchroniser and change compare
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_detect (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // Pin samples and configuration
  input  wire logic [pmw_pkg::NUM_PINS-1:0] pin_raw,
  input  wire logic [pmw_pkg::NUM_PINS-1:0] wake_en,
  input  wire logic [pmw_pkg::NUM_PINS-1:0] trig_lo,
  input  wire logic [pmw_pkg::NUM_PINS-1:0] trig_hi,
  input  wire logic [pmw_pkg::NUM_PINS-1:0] in_dis,
  // Results
  output logic      [pmw_pkg::NUM_PINS-1:0] pin_sync,
  output logic      [pmw_pkg::NUM_PINS-1:0] hit
);
  logic [pmw_pkg::NUM_PINS-1:0] meta;
  logic [pmw_pkg::NUM_PINS-1:0] prev;
  logic [pmw_pkg::NUM_PINS-1:0] live;

  // Two stage sync; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta     <= '0;
      pin_sync <= '0;
      prev     <= '0;
    end else begin
      meta     <= pin_raw;
      pin_sync <= meta;
      prev     <= pin_sync;
    end
  end

  // Disconnected input buffer reads low and cannot wake
  assign live = pin_sync & ~in_dis;

  always_comb begin
    for (int i = 0; i < pmw_pkg::NUM_PINS; i++) begin
      case ({trig_hi[i], trig_lo[i]})
        pmw_pkg::TRIG_LOW:    hit[i] = wake_en[i] & ~in_dis[i] & ~live[i];
        pmw_pkg::TRIG_HIGH:   hit[i] = wake_en[i] & live[i];
        pmw_pkg::TRIG_CHANGE: hit[i] = wake_en[i] & ~in_dis[i] & (pin_sync[i] ^ prev[i]);
        default:              hit[i] = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pmw_ctrl.sv */
// Power mode and wake controller top with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl #(
  parameter int RST_CYCLES = pmw_pkg::RST_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // External reset pin
  input  wire logic                         external_reset_n,
  // Avalon-MM slave
  input  wire logic [pmw_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // Peripheral interrupt sources
  input  wire logic                         uart_rx_irq,
  input  wire logic                         radio_rx_irq,
  // Wake capable pins
  input  wire logic [pmw_pkg::NUM_PINS-1:0] wake_capable_pin_in,
  output logic      [pmw_pkg::NUM_PINS-1:0] wake_capable_pin_out,
  output logic      [pmw_pkg::NUM_PINS-1:0] wake_capable_pin_oe_n,
  output logic      [pmw_pkg::NUM_PINS-1:0] pull_up_en,
  output logic      [pmw_pkg::NUM_PINS-1:0] pull_down_en,
  output logic      [pmw_pkg::NUM_PINS-1:0] input_buf_dis,
  // Power status
  output logic      [1:0]                   power_state,
  output logic                              system_reset,
  output logic                              irq
);
  localparam int NP = pmw_pkg::NUM_PINS;

  pmw_pkg::pmw_state_t state;
  logic [NP-1:0] wake_en, trig_lo, trig_hi, dir_out, pu, pd, in_dis, out_val;
  logic [NP-1:0] pin_sync, pin_hit;
  logic [1:0]    irq_src_en;
  logic [2:0]    irq_st, irq_msk;
  logic [1:0]    cmd_req;
  logic          wake_latch, any_irq;
  logic          ext_meta, ext_sync;
  logic [31:0]   ext_cnt;
  logic          ext_fire;
  logic [4:0]    rst_cnt;
  logic          ack;
  logic [31:0]   next_rdata;
  logic          wr_hit, wr_bad, next_err;
  logic [2:0]    irq_set;

  // Byte-lane merge used for the eight pin and wake configuration registers
  function automatic logic [NP-1:0] merge(input logic [NP-1:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = {{(32-NP){1'b0}}, old};
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r[NP-1:0];
  endfunction

  pmw_wake_detect u_det (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .pin_raw  (wake_capable_pin_in),
    .wake_en  (wake_en),
    .trig_lo  (trig_lo),
    .trig_hi  (trig_hi),
    .in_dis   (in_dis),
    .pin_sync (pin_sync),
    .hit      (pin_hit)
  );

  // One wait cycle per access outside system reset keeps read data registered
  always_ff @(posedge sys_clk) begin
    if (!resetn || system_reset) ack <= 1'b0;
    else ack <= (avs_read || avs_write) && !ack;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_hit = avs_write && ack;

  // External reset pin sync and low-time counter
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      ext_cnt  <= '0;
    end else begin
      ext_meta <= external_reset_n;
      ext_sync <= ext_meta;
      if (ext_sync) ext_cnt <= '0;
      else if (ext_cnt < 32'(RST_CYCLES)) ext_cnt <= ext_cnt + 32'h1;
    end
  end
  // Fires once, on reaching the full low time; short pulses are ignored
  assign ext_fire = !ext_sync && (ext_cnt == 32'(RST_CYCLES) - 32'h1);

  // Pin and wake configuration; context retained through sleep, cleared by system reset except irq_src_en, which returns to 3
  always_ff @(posedge sys_clk) begin
    if (!resetn || system_reset) begin
      wake_en <= '0; trig_lo <= '0; trig_hi <= '0; dir_out <= '0;
      pu <= '0; pd <= '0; in_dis <= '0; out_val <= '0;
      irq_msk <= '0; irq_src_en <= 2'h3;
    end else if (wr_hit) begin
      case (avs_address)
        pmw_pkg::REG_WAKE_EN: wake_en <= merge(wake_en, avs_writedata, avs_byteenable);
        pmw_pkg::REG_TRIG_LO: trig_lo <= merge(trig_lo, avs_writedata, avs_byteenable);
        pmw_pkg::REG_TRIG_HI: trig_hi <= merge(trig_hi, avs_writedata, avs_byteenable);
        pmw_pkg::REG_DIR:     dir_out <= merge(dir_out, avs_writedata, avs_byteenable);
        pmw_pkg::REG_PULL_UP: pu      <= merge(pu, avs_writedata, avs_byteenable);
        pmw_pkg::REG_PULL_DN: pd      <= merge(pd, avs_writedata, avs_byteenable);
        pmw_pkg::REG_IN_DIS:  in_dis  <= merge(in_dis, avs_writedata, avs_byteenable);
        pmw_pkg::REG_OUT:     out_val <= merge(out_val, avs_writedata, avs_byteenable);
        pmw_pkg::REG_IRQ_MSK: if (avs_byteenable[0]) irq_msk <= avs_writedata[2:0];
        pmw_pkg::REG_IRQ_SRC: if (avs_byteenable[0]) irq_src_en <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // Pull-up wins when software sets both, avoiding a divider on the pad
  assign pull_up_en            = pu;
  assign pull_down_en          = pd & ~pu;
  assign input_buf_dis         = in_dis;
  assign wake_capable_pin_out  = out_val;
  assign wake_capable_pin_oe_n = ~dir_out;

  // Mode request from the control register
  always_comb begin
    cmd_req = 2'h0;
    if (wr_hit && avs_address == pmw_pkg::REG_CTRL && avs_byteenable[0]) begin
      cmd_req = avs_writedata[1:0];
    end
  end

  assign any_irq = (uart_rx_irq && irq_src_en[0]) || (radio_rx_irq && irq_src_en[1]);

  // Wake latch holds until the state change completes
  always_ff @(posedge sys_clk) begin
    if (!resetn || system_reset) wake_latch <= 1'b0;
    else if (state == pmw_pkg::PMW_RUN) wake_latch <= 1'b0;
    else if ((state == pmw_pkg::PMW_SLEEP && (any_irq || |pin_hit)) ||
             (state == pmw_pkg::PMW_OFF && |pin_hit)) wake_latch <= 1'b1;
  end

  // Three power states plus a reset pulse phase
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state   <= pmw_pkg::PMW_RUN;
      rst_cnt <= '0;
    end else if (ext_fire) begin
      state   <= pmw_pkg::PMW_RESET;
      rst_cnt <= '0;
    end else begin
      case (state)
        pmw_pkg::PMW_RUN: begin
          if (cmd_req[pmw_pkg::CTRL_OFF]) state <= pmw_pkg::PMW_OFF;
          else if (cmd_req[pmw_pkg::CTRL_SLEEP]) state <= pmw_pkg::PMW_SLEEP;
        end
        pmw_pkg::PMW_SLEEP: begin
          if (wake_latch) state <= pmw_pkg::PMW_RUN;
        end
        pmw_pkg::PMW_OFF: begin
          if (wake_latch) begin
            state   <= pmw_pkg::PMW_RESET;
            rst_cnt <= '0;
          end
        end
        pmw_pkg::PMW_RESET: begin
          rst_cnt <= rst_cnt + 5'h1;
          if (rst_cnt == 5'(pmw_pkg::SYSRST_LEN - 1)) state <= pmw_pkg::PMW_RUN;
        end
        default: state <= pmw_pkg::PMW_RUN;
      endcase
    end
  end

  assign system_reset = (state == pmw_pkg::PMW_RESET);
  assign power_state  = state;

  // Unmapped or illegal write flags an error
  assign wr_bad   = wr_hit && (avs_address > pmw_pkg::REG_IRQ_SRC ||
                               avs_address == pmw_pkg::REG_STATE ||
                               avs_address == pmw_pkg::REG_PIN_IN);
  assign next_err = wr_bad || (cmd_req == 2'h3);

  // Status set events, one per bit
  always_comb begin
    irq_set                       = 3'h0;
    irq_set[pmw_pkg::IRQ_WOKE]    = (state == pmw_pkg::PMW_SLEEP) && wake_latch;
    irq_set[pmw_pkg::IRQ_RESTART] = (state == pmw_pkg::PMW_RESET) && (rst_cnt == 5'h0);
    irq_set[pmw_pkg::IRQ_ERR]     = next_err;
  end

  // Sticky status; set wins over write-one-to-clear; restart event survives its own reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) irq_st <= '0;
    else begin
      for (int k = 0; k < 3; k++) begin
        if (irq_set[k]) irq_st[k] <= 1'b1;
        else if (wr_hit && avs_address == pmw_pkg::REG_IRQ_ST && avs_byteenable[0] &&
                 avs_writedata[k]) irq_st[k] <= 1'b0;
      end
    end
  end
  assign irq = |(irq_st & irq_msk);

  always_comb begin
    case (avs_address)
      pmw_pkg::REG_CTRL:    next_rdata = 32'h0;
      pmw_pkg::REG_STATE:   next_rdata = {30'h0, state};
      pmw_pkg::REG_WAKE_EN: next_rdata = 32'(wake_en);
      pmw_pkg::REG_TRIG_LO: next_rdata = 32'(trig_lo);
      pmw_pkg::REG_TRIG_HI: next_rdata = 32'(trig_hi);
      pmw_pkg::REG_DIR:     next_rdata = 32'(dir_out);
      pmw_pkg::REG_PULL_UP: next_rdata = 32'(pu);
      pmw_pkg::REG_PULL_DN: next_rdata = 32'(pd);
      pmw_pkg::REG_IN_DIS:  next_rdata = 32'(in_dis);
      pmw_pkg::REG_OUT:     next_rdata = 32'(out_val);
      pmw_pkg::REG_PIN_IN:  next_rdata = 32'(pin_sync & ~in_dis);
      pmw_pkg::REG_IRQ_ST:  next_rdata = {29'h0, irq_st};
      pmw_pkg::REG_IRQ_MSK: next_rdata = {29'h0, irq_msk};
      pmw_pkg::REG_IRQ_SRC: next_rdata = {30'h0, irq_src_en};
      default:              next_rdata = pmw_pkg::UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) avs_readdata <= '0;
    else if (avs_read && !ack) avs_readdata <= next_rdata;
  end
endmodule
`default_nettype wire

/* File: verification/pmw_ctrl_assertions.sv */
// Port-level assertions for the power mode and wake controller
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl_assertions #(
  parameter int RST_CYCLES = 20
) (
  // Clock, resets
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        external_reset_n,
  // Bus handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Wake sources and pads
  input wire logic        uart_rx_irq,
  input wire logic        radio_rx_irq,
  input wire logic [18:0] pull_up_en,
  input wire logic [18:0] pull_down_en,
  // Power status
  input wire logic [1:0]  power_state,
  input wire logic        system_reset
);
  logic [4:0]  rst_len;
  logic [31:0] low_len;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk) begin
    rst_len <= (resetn && power_state == 2'h2) ? rst_len + 5'h1 : 5'h0;
  end
  // Saturates so a long hold cannot wrap
  always_ff @(posedge sys_clk) begin
    if (!resetn || external_reset_n) begin
      low_len <= 32'h0;
    end else if (low_len != 32'hFFFFFFFF) begin
      low_len <= low_len + 32'h1;
    end
  end
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
    && power_state != 2'h2 |=> !avs_waitrequest || power_state == 2'h2)
    else $error("more than one wait cycle");
  AST_IDLE_READY: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  AST_SYSRST_OUT: assert property (system_reset == (power_state == 2'h2))
    else $error("system reset mismatch");
  AST_OFF_EXIT: assert property (power_state == 2'h3 ##1 power_state != 2'h3
    |-> power_state == 2'h2) else $error("off left without reset");
  AST_SYSRST_LEN: assert property (power_state != 2'h2 && rst_len != 5'h0
    |-> rst_len == 5'h10) else $error("reset pulse length wrong");
  AST_SLEEP_WAKE: assert property (power_state == 2'h1
    && (uart_rx_irq || radio_rx_irq) |-> ##[1:4] power_state == 2'h0)
    else $error("no wake from sleep");
  AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == 19'h0)
    else $error("both pulls on");
  AST_EXT_LONG: assert property (low_len == RST_CYCLES
    |-> ##[0:6] power_state == 2'h2) else $error("long reset ignored");
  // Low time taken two edges before entry; a minimum hold is already released then
  AST_EXT_SHORT: assert property ($rose(power_state == 2'h2)
    && $past(power_state) != 2'h3 |-> $past(low_len, 2) >= RST_CYCLES)
    else $error("reset from short pulse");
endmodule
bind pmw_ctrl pmw_ctrl_assertions #(.RST_CYCLES(RST_CYCLES)) u_chk (
  .sys_clk, .resetn, .external_reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .uart_rx_irq, .radio_rx_irq, .pull_up_en, .pull_down_en, .power_state, .system_reset
);
`default_nettype wire

/* File: verification/pmw_host_model.sv */
// Host model driving the wake pins and the reset pin
`timescale 1ns/10ps
`default_nettype none
module pmw_host_model (
  // Clock and controller pin drive
  input  wire logic        sys_clk,
  input  wire logic [18:0] pin_out,
  input  wire logic [18:0] pin_oe_n,
  // Pin levels and reset pin
  output logic      [18:0] pin_level,
  output logic             external_reset_n
);
  logic [18:0] drv;
  initial begin
    drv = 19'h0;
    external_reset_n = 1'b1;
  end
  // Controller wins where it drives
  assign pin_level = (pin_oe_n & drv) | (~pin_oe_n & pin_out);
  task automatic set_pin(input int i, input logic v);
    @(posedge sys_clk);
    drv[i] <= v;
  endtask
  // Short holds are a deliberate fault
  task automatic hold_reset(input int n);
    @(posedge sys_clk);
    external_reset_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    external_reset_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_pmw_ctrl.sv */
// Self-checking bench for the power mode and wake controller
`timescale 1ns/10ps
`default_nettype none
module tb_pmw_ctrl;
  localparam int RC = 20;
  logic        sys_clk = 0, resetn = 0, rd = 0, wr = 0, uart = 0, radio = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic        wreq, xrst_n, sreset, irq;
  logic [18:0] pin, pout, oen, pu, pd, ibd;
  logic [1:0]  pst;
  int          error_cnt = 0, n_compared = 0;
  always #12.5 sys_clk = ~sys_clk;
  pmw_ctrl #(.RST_CYCLES(RC)) u_dut (.sys_clk, .resetn, .external_reset_n(xrst_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .uart_rx_irq(uart), .radio_rx_irq(radio), .wake_capable_pin_in(pin),
    .wake_capable_pin_out(pout), .wake_capable_pin_oe_n(oen), .pull_up_en(pu),
    .pull_down_en(pd), .input_buf_dis(ibd), .power_state(pst), .system_reset(sreset), .irq);
  pmw_host_model u_host (.sys_clk, .pin_out(pout), .pin_oe_n(oen), .pin_level(pin),
    .external_reset_n(xrst_n));
  function automatic logic [31:0] cfg(input logic [31:0] v);
    return v & 32'h7FFFF;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // No local limit; only the watchdog ends a stuck access
    do begin
      @(posedge sys_clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    while (pst !== s && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(pst), 32'(s));
  endtask
  task automatic done(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [31:0] d [10];
    int          k;
    logic        lv;
    void'($urandom(84));
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus(0, pmw_pkg::REG_IRQ_SRC, 32'h0);
    chk(q, 32'h3);
    chk(32'(oen), 32'h7FFFF);
    done("reset");
    for (int a = 2; a < 10; a++) begin
      d[a] = $urandom();
      bus(1, 4'(a), d[a]);
    end
    for (int a = 2; a < 10; a++) begin
      bus(0, 4'(a), 32'h0);
      chk(q, cfg(d[a]));
    end
    chk(32'(oen), cfg(~d[5]));
    chk(32'(pu), cfg(d[6]));
    chk(32'(pd), cfg(d[7] & ~d[6]));
    chk(32'(ibd), cfg(d[8]));
    chk(32'(pout), cfg(d[9]));
    bus(0, pmw_pkg::REG_PIN_IN, 32'h0);
    chk(q, cfg(d[9] & d[5] & ~d[8]));
    bus(0, 4'hE, 32'h0);
    chk(q, pmw_pkg::UNMAPPED_RD);
    bus(1, pmw_pkg::REG_STATE, 32'h1);
    chk(32'(irq), 32'h0);
    bus(1, pmw_pkg::REG_IRQ_MSK, 32'h4);
    chk(32'(irq), 32'h1);
    bus(1, pmw_pkg::REG_IRQ_ST, 32'h7);
    chk(32'(irq), 32'h0);
    done("regs");
    for (int a = 2; a < 10; a++) bus(1, 4'(a), 32'h0);
    for (int s = 0; s < 2; s++) begin
      // Clear the woke bit so each source proves itself
      bus(1, pmw_pkg::REG_IRQ_ST, 32'h1 << pmw_pkg::IRQ_WOKE);
      bus(1, pmw_pkg::REG_CTRL, 32'h1);
      wait_st(2'h1);
      uart <= (s == 0);
      radio <= (s == 1);
      wait_st(2'h0);
      uart <= 1'b0;
      radio <= 1'b0;
      bus(0, pmw_pkg::REG_IRQ_ST, 32'h0);
      chk(q & 32'h1, 32'h1);
    end
    // Low, high, then change trigger on a random pin
    for (int m = 0; m < 3; m++) begin
      k = $urandom_range(18);
      lv = (m == 0) ? 1'b1 : (m == 1) ? 1'b0 : 1'($urandom());
      u_host.set_pin(k, lv);
      bus(1, pmw_pkg::REG_TRIG_LO, 32'(m == 1) << k);
      bus(1, pmw_pkg::REG_TRIG_HI, 32'(m == 2) << k);
      bus(1, pmw_pkg::REG_WAKE_EN, 32'h1 << k);
      bus(1, pmw_pkg::REG_CTRL, 32'h1);
      repeat (6) @(posedge sys_clk);
      chk(32'(pst), 32'h1);
      u_host.set_pin(k, !lv);
      wait_st(2'h0);
    end
    done("sleep");
    // Output on another pin, so the host still owns the wake pin
    bus(1, pmw_pkg::REG_DIR, 32'h1 << ((k + 1) % pmw_pkg::NUM_PINS));
    bus(1, pmw_pkg::REG_CTRL, 32'h2);
    wait_st(2'h3);
    u_host.set_pin(k, lv);
    wait_st(2'h2);
    chk(32'(sreset), 32'h1);
    wait_st(2'h0);
    bus(0, pmw_pkg::REG_DIR, 32'h0);
    chk(q, 32'h0);
    bus(0, pmw_pkg::REG_IRQ_ST, 32'h0);
    chk(q & 32'h2, 32'h2);
    done("deep");
    // One cycle short of the minimum is ignored
    u_host.hold_reset(RC - 1);
    repeat (10) @(posedge sys_clk);
    chk(32'(pst), 32'h0);
    bus(1, pmw_pkg::REG_DIR, 32'h1);
    // Exactly the minimum low time resets
    u_host.hold_reset(RC);
    wait_st(2'h2);
    chk(32'(sreset), 32'h1);
    wait_st(2'h0);
    bus(0, pmw_pkg::REG_DIR, 32'h0);
    chk(q, 32'h0);
    done("ext reset");
    summarize();
  end
endmodule
`default_nettype wire
